// *** pkg/card_cfg_pkg.sv ***
// card_cfg_pkg: constants and types for the card mode and option register
// assumes one 10 MHz clock domain; host strobes arrive already on it
`default_nettype none
package card_cfg_pkg;

  localparam int unsigned ATTR_ADDR_W = 11;
  localparam logic [10:0] CFG_OPT_OFFSET = 11'h200;
  localparam logic [7:0] CFG_OPT_RESET = 8'h00;
  localparam logic [7:0] RDATA_IDLE = 8'h00;
  localparam int unsigned SRST_BIT = 7;
  localparam int unsigned LEVEL_BIT = 6;
  localparam int unsigned INDEX_LSB = 0;
  localparam int unsigned INDEX_W = 6;
  localparam int unsigned DECODE_LSB = 0;
  localparam int unsigned DECODE_W = 2;

  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned IRQ_PULSE_MIN_NS = 500;
  localparam int unsigned IRQ_PULSE_CYCLES =
    (IRQ_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [1:0] SENSE_SETTLE_LAST = 2'h1;

  typedef enum logic [0:0] {
    MODE_PC_ATA = 1'h0,
    MODE_TRUE_IDE = 1'h1
  } host_mode_t;

  typedef enum logic [1:0] {
    DEC_COMMON_LINEAR = 2'h0,
    DEC_IO_INDEPENDENT = 2'h1,
    DEC_IO_PRIMARY = 2'h2,
    DEC_IO_SECONDARY = 2'h3
  } decode_t;

  typedef enum logic [2:0] {
    BOOT_SETTLE = 3'h1,
    BOOT_LATCH = 3'h2,
    BOOT_RUN = 3'h4
  } boot_t;

  typedef enum logic [1:0] {
    IRQ_IDLE = 2'h1,
    IRQ_PULSE = 2'h2
  } irq_state_t;

endpackage
`default_nettype wire

// *** pkg/irq_link_if.sv ***
// irq_link_if: control from the option register to the interrupt signaller
// assumes both ends share one clock; no timing of its own
`timescale 1ns/1ps
`default_nettype none
interface irq_link_if;
  logic level_sel;
  logic quiet;
  logic raise;
  logic serviced;
  logic line_n;
  logic line_oe;

  modport ctrl (
    output level_sel,
    output quiet,
    output raise,
    output serviced,
    input line_n,
    input line_oe
  );

  modport sig (
    input level_sel,
    input quiet,
    input raise,
    input serviced,
    output line_n,
    output line_oe
  );
endinterface
`default_nettype wire

// *** logic/host_irq_signaller.sv ***
// host_irq_signaller: drives the active-low host interrupt line
// assumes raise and serviced are one-cycle strobes on the same clock
`timescale 1ns/1ps
`default_nettype none
module host_irq_signaller
  import card_cfg_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = IRQ_PULSE_CYCLES
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  irq_link_if.sig b
);

  localparam int unsigned CNT_W =
    (PULSE_CYCLES > 1) ? $clog2(PULSE_CYCLES) : 1;

  irq_state_t state_q;
  irq_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic pending_q;
  logic pending_d;
  logic line_n_q;
  logic line_n_d;
  logic oe_q;
  logic start_pulse;

  // a new event beats a service strobe in the same cycle
  assign pending_d = ~b.quiet & (b.raise | (pending_q & ~b.serviced));
  assign start_pulse = ~b.quiet & ~b.level_sel & b.raise;

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      IRQ_IDLE:
      begin
        if (start_pulse)
        begin
          state_d = IRQ_PULSE;
          cnt_d = CNT_W'(PULSE_CYCLES - 1);
        end
      end
      IRQ_PULSE:
      begin
        // events during a pulse merge into it
        if (b.quiet || b.level_sel || cnt_q == '0)
          state_d = IRQ_IDLE;
        else
          cnt_d = cnt_q - CNT_W'(1);
      end
      default:
        state_d = IRQ_IDLE;
    endcase
  end

  // level mode follows pending; pulse mode follows the pulse state
  assign line_n_d = b.level_sel ? ~pending_d : (state_d != IRQ_PULSE);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= IRQ_IDLE;
      cnt_q <= '0;
      pending_q <= 1'h0;
      line_n_q <= 1'h1;
      oe_q <= 1'h0;
    end
    else if (ce_i)
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pending_q <= pending_d;
      line_n_q <= line_n_d;
      oe_q <= ~b.quiet;
    end
  end

  assign b.line_n = line_n_q;
  assign b.line_oe = oe_q;

  property p_pulse_width;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && state_q == IRQ_IDLE && start_pulse) |=>
      (!b.line_n || b.quiet || b.level_sel) [*5];
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("pulsed interrupt shorter than minimum width");

  property p_level_hold;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && b.level_sel && pending_q && !b.serviced && !b.quiet) |=>
      !b.line_n;
  endproperty
  a_level_hold: assert property (p_level_hold)
    else $error("level interrupt released before service");

endmodule
`default_nettype wire

// *** logic/card_mode_config_register.sv ***
// card_mode_config_register: host mode selection and option register
// assumes attribute strobes come from a same-clock bus front end;
// host reset and mode sense are raw pins and are synchronised here
`timescale 1ns/1ps
`default_nettype none
module card_mode_config_register
  import card_cfg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic host_reset_line_i,
  input wire logic mode_sense_i,
  input wire logic cpu_mode_we_i,
  input wire logic cpu_mode_i,
  input wire logic attr_space_i,
  input wire logic [ATTR_ADDR_W-1:0] attr_addr_i,
  input wire logic attr_we_i,
  input wire logic attr_re_i,
  input wire logic [7:0] attr_wdata_i,
  input wire logic irq_event_i,
  input wire logic irq_serviced_i,
  output logic [7:0] attr_rdata_o,
  output logic attr_rvalid_o,
  output logic mode_valid_o,
  output host_mode_t host_mode_o,
  output logic host_if_reset_o,
  output logic level_irq_select_o,
  output logic [INDEX_W-1:0] config_index_o,
  output decode_t decode_sel_o,
  output logic irq_n_o,
  output logic irq_oe_o
);

  logic hrst_s1_q;
  logic hrst_s2_q;
  logic sense_s1_q;
  logic sense_s2_q;
  boot_t boot_q;
  boot_t boot_d;
  logic [1:0] settle_q;
  logic [1:0] settle_d;
  host_mode_t mode_q;
  host_mode_t mode_d;
  logic valid_q;
  logic valid_d;
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic host_if_reset_q;
  logic host_if_reset_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic cfg_hit;
  logic cfg_wr;
  logic cfg_rd;
  logic hrst_clear;

  irq_link_if irq_b ();

  // raw pins: only the second stage is read anywhere
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hrst_s1_q <= 1'h0;
      hrst_s2_q <= 1'h0;
      sense_s1_q <= 1'h0;
      sense_s2_q <= 1'h0;
    end
    else if (ce_i)
    begin
      hrst_s1_q <= host_reset_line_i;
      hrst_s2_q <= hrst_s1_q;
      sense_s1_q <= mode_sense_i;
      sense_s2_q <= sense_s1_q;
    end
  end

  // wait for the sense synchroniser to fill before trusting it
  always_comb
  begin
    boot_d = boot_q;
    settle_d = settle_q;
    mode_d = mode_q;
    valid_d = valid_q;
    case (boot_q)
      BOOT_SETTLE:
      begin
        if (settle_q == SENSE_SETTLE_LAST)
          boot_d = BOOT_LATCH;
        else
          settle_d = settle_q + 2'h1;
      end
      BOOT_LATCH:
      begin
        mode_d = host_mode_t'(sense_s2_q);
        valid_d = 1'h1;
        boot_d = BOOT_RUN;
      end
      BOOT_RUN:
      begin
        // override only after the sensed mode is in, so it is not undone
        if (cpu_mode_we_i)
          mode_d = host_mode_t'(cpu_mode_i);
      end
      default:
        boot_d = BOOT_SETTLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      boot_q <= BOOT_SETTLE;
      settle_q <= 2'h0;
      mode_q <= MODE_PC_ATA;
      valid_q <= 1'h0;
    end
    else if (ce_i)
    begin
      boot_q <= boot_d;
      settle_q <= settle_d;
      mode_q <= mode_d;
      valid_q <= valid_d;
    end
  end

  assign cfg_hit = attr_space_i && (attr_addr_i == CFG_OPT_OFFSET);
  assign cfg_wr = cfg_hit && attr_we_i;
  assign cfg_rd = cfg_hit && attr_re_i;
  // host reset line only clears the option register once a mode has been configured
  assign hrst_clear = valid_q && hrst_s2_q;
  assign cfg_d = hrst_clear ? CFG_OPT_RESET :
                 (cfg_wr ? attr_wdata_i : cfg_q);
  assign host_if_reset_d = cfg_d[SRST_BIT] | hrst_s2_q;
  // unmapped attribute reads answer zero rather than stale data
  assign rdata_d = cfg_rd ? cfg_q : RDATA_IDLE;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cfg_q <= CFG_OPT_RESET;
      host_if_reset_q <= 1'h0;
      rdata_q <= RDATA_IDLE;
      rvalid_q <= 1'h0;
    end
    else if (ce_i)
    begin
      cfg_q <= cfg_d;
      host_if_reset_q <= host_if_reset_d;
      rdata_q <= rdata_d;
      rvalid_q <= attr_re_i;
    end
  end

  assign irq_b.level_sel = cfg_q[LEVEL_BIT];
  assign irq_b.quiet = host_if_reset_q;
  assign irq_b.raise = irq_event_i;
  assign irq_b.serviced = irq_serviced_i;

  host_irq_signaller #(
    .PULSE_CYCLES(IRQ_PULSE_CYCLES)
  ) u_irq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .b(irq_b.sig)
  );

  assign attr_rdata_o = rdata_q;
  assign attr_rvalid_o = rvalid_q;
  assign mode_valid_o = valid_q;
  assign host_mode_o = mode_q;
  assign host_if_reset_o = host_if_reset_q;
  assign level_irq_select_o = cfg_q[LEVEL_BIT];
  assign config_index_o = cfg_q[INDEX_LSB +: INDEX_W];
  assign decode_sel_o = decode_t'(cfg_q[DECODE_LSB +: DECODE_W]);
  assign irq_n_o = irq_b.line_n;
  assign irq_oe_o = irq_b.line_oe;

  property p_boot_latch;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && boot_q == BOOT_LATCH) |=>
      (mode_valid_o && host_mode_o == host_mode_t'($past(sense_s2_q)));
  endproperty
  a_boot_latch: assert property (p_boot_latch)
    else $error("sensed mode not taken at power-up");

  property p_boot_bound;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && boot_q == BOOT_SETTLE && settle_q == 2'h0) ##1 ce_i ##1 ce_i
      |=> mode_valid_o;
  endproperty
  a_boot_bound: assert property (p_boot_bound)
    else $error("mode not settled three enabled cycles after reset");

  property p_override;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && boot_q == BOOT_RUN && cpu_mode_we_i) |=>
      host_mode_o == host_mode_t'($past(cpu_mode_i));
  endproperty
  a_override: assert property (p_override)
    else $error("local mode override not applied");

  property p_reg_read;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && cfg_rd) |=> (attr_rvalid_o && attr_rdata_o == $past(cfg_q));
  endproperty
  a_reg_read: assert property (p_reg_read)
    else $error("option register read returned wrong value");

  property p_reg_write;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && cfg_wr && !hrst_clear) |=>
      (level_irq_select_o == $past(attr_wdata_i[LEVEL_BIT]) &&
       decode_sel_o == decode_t'($past(attr_wdata_i[1:0])) &&
       config_index_o == $past(attr_wdata_i[5:0]));
  endproperty
  a_reg_write: assert property (p_reg_write)
    else $error("option register write not applied");

  property p_no_stray_write;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && !cfg_wr && !hrst_clear) |=> $stable(cfg_q);
  endproperty
  a_no_stray_write: assert property (p_no_stray_write)
    else $error("option register changed without a write");

  property p_host_reset_clear;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && valid_q && hrst_s2_q) |=>
      (cfg_q == CFG_OPT_RESET && host_if_reset_o);
  endproperty
  a_host_reset_clear: assert property (p_host_reset_clear)
    else $error("host reset line did not clear option register");

  property p_soft_reset;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && cfg_wr && !hrst_clear) |=>
      (host_if_reset_o == ($past(attr_wdata_i[SRST_BIT]) ||
                           $past(hrst_s2_q)));
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset bit not reflected on host interface reset");

endmodule
`default_nettype wire

// *** sim/host_model.sv ***
// host_model: host side of the attribute bus plus interrupt service
// assumes callers sit just after a rising clk_i edge
`timescale 1ns/1ps
`default_nettype none
module host_model
  import card_cfg_pkg::*;
(
  input wire logic clk_i,
  input wire logic [7:0] attr_rdata_i,
  input wire logic attr_rvalid_i,
  output logic attr_space_o,
  output logic [ATTR_ADDR_W-1:0] attr_addr_o,
  output logic attr_we_o,
  output logic attr_re_o,
  output logic [7:0] attr_wdata_o,
  output logic serviced_o
);
  initial
  begin
    attr_space_o = 1'b0;
    attr_addr_o = '0;
    attr_we_o = 1'b0;
    attr_re_o = 1'b0;
    attr_wdata_o = 8'h00;
    serviced_o = 1'b0;
  end

  // data flips on release so a stale byte never matches by luck
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    attr_space_o = 1'b1;
    attr_addr_o = a;
    attr_wdata_o = d;
    attr_we_o = 1'b1;
    @(posedge clk_i);
    #1;
    attr_we_o = 1'b0;
    attr_space_o = 1'b0;
    attr_wdata_o = ~d;
  endtask

  task automatic rd(input logic [10:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge clk_i);
    #1;
    attr_space_o = 1'b1;
    attr_addr_o = a;
    attr_re_o = 1'b1;
    @(posedge clk_i);
    #1;
    attr_re_o = 1'b0;
    attr_space_o = 1'b0;
    d = attr_rdata_i;
    v = attr_rvalid_i;
  endtask

  task automatic service;
    @(posedge clk_i);
    #1;
    serviced_o = 1'b1;
    @(posedge clk_i);
    #1;
    serviced_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// tb_top: self-checking bench for the card mode and option register
// assumes the host model owns the attribute bus; bench drives clock enable
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import card_cfg_pkg::*;
;
  logic clk, rst, hrst, sense, cpu_we, cpu_m, ev, svc, ce;
  logic space, we, re, rvalid, mvalid, hif_rst, level, irq_n, irq_oe, v;
  logic [10:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [INDEX_W-1:0] idx;
  host_mode_t hmode;
  decode_t dsel;
  int n_fail, checks, n;

  card_mode_config_register dut (.clk_i(clk), .rst_i(rst), .ce_i(ce),
    .host_reset_line_i(hrst), .mode_sense_i(sense), .cpu_mode_we_i(cpu_we),
    .cpu_mode_i(cpu_m), .attr_space_i(space), .attr_addr_i(addr),
    .attr_we_i(we), .attr_re_i(re), .attr_wdata_i(wdata),
    .irq_event_i(ev), .irq_serviced_i(svc), .attr_rdata_o(rdata),
    .attr_rvalid_o(rvalid), .mode_valid_o(mvalid), .host_mode_o(hmode),
    .host_if_reset_o(hif_rst), .level_irq_select_o(level),
    .config_index_o(idx), .decode_sel_o(dsel), .irq_n_o(irq_n),
    .irq_oe_o(irq_oe));

  host_model host (.clk_i(clk), .attr_rdata_i(rdata),
    .attr_rvalid_i(rvalid), .attr_space_o(space), .attr_addr_o(addr),
    .attr_we_o(we), .attr_re_o(re), .attr_wdata_o(wdata),
    .serviced_o(svc));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic fail(input string what);
    n_fail++;
    $display("unexpected at %0t: %s", $time, what);
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp)
      fail(what);
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
    checks++;
    if (got !== exp)
      fail(what);
  endtask

  task automatic wrap_up;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // bounded wait; a stuck sense sequence ends the run
  task automatic wait_mode;
    n = 0;
    while (mvalid !== 1'b1 && n < 10)
    begin
      n++;
      tick();
    end
    if (mvalid !== 1'b1)
    begin
      fail("mode never valid");
      wrap_up();
    end
  endtask

  task automatic reg_is(input logic [7:0] exp, input string what);
    host.rd(CFG_OPT_OFFSET, d, v);
    chk1(v, 1'b1, "read answer");
    chk8(d, exp, what);
  endtask

  task automatic pulse_event;
    ev = 1'b1;
    tick();
    ev = 1'b0;
  endtask

  initial
  begin
    n_fail = 0;
    checks = 0;
    rst = 1'b1;
    hrst = 1'b0;
    sense = 1'b1;
    cpu_we = 1'b0;
    cpu_m = 1'b0;
    ev = 1'b0;
    ce = 1'b1;
    repeat (6) tick();
    rst = 1'b0;
    wait_mode();
    chk1(hmode, MODE_TRUE_IDE, "sensed mode");
    reg_is(CFG_OPT_RESET, "power-on value");
    for (int i = 0; i < 2; i++)
    begin
      cpu_m = i[0];
      cpu_we = 1'b1;
      tick();
      cpu_we = 1'b0;
      chk1(hmode, i[0], "override");
    end
    for (int i = 0; i < 4; i++)
    begin
      host.wr(CFG_OPT_OFFSET, 8'h3C | 8'(i));
      chk8(8'(dsel), 8'(i), "decode select");
      chk8(8'(idx), 8'h3C | 8'(i), "config index");
    end
    host.wr(CFG_OPT_OFFSET, 8'h41);
    chk1(level, 1'b1, "level select");
    reg_is(8'h41, "readback");
    host.rd(11'h201, d, v);
    chk1(v, 1'b1, "unmapped answer");
    chk8(d, RDATA_IDLE, "unmapped read");
    pulse_event();
    chk1(irq_n, 1'b0, "level irq start");
    repeat (20) tick();
    chk1(irq_n, 1'b0, "level irq held");
    host.service();
    chk1(irq_n, 1'b1, "level irq cleared");
    chk1(irq_oe, 1'b1, "line driven idle");
    host.wr(CFG_OPT_OFFSET, 8'h00);
    chk1(level, 1'b0, "pulse select");
    pulse_event();
    n = 0;
    while (irq_n === 1'b0 && n < 20)
    begin
      n++;
      tick();
    end
    if (irq_n === 1'b0)
    begin
      fail("pulse never ended");
      wrap_up();
    end
    chk8(8'(n), 8'(IRQ_PULSE_CYCLES), "pulse width");
    host.wr(CFG_OPT_OFFSET, 8'h80);
    chk1(hif_rst, 1'b1, "soft reset on");
    reg_is(8'h80, "soft reset bit");
    pulse_event();
    tick();
    chk1(irq_n, 1'b1, "irq in reset");
    chk1(irq_oe, 1'b0, "line released in reset");
    host.wr(CFG_OPT_OFFSET, 8'h00);
    chk1(hif_rst, 1'b0, "soft reset off");
    // a write seen with the enable low must leave no trace
    ce = 1'b0;
    host.wr(CFG_OPT_OFFSET, 8'hFF);
    ce = 1'b1;
    reg_is(8'h00, "write frozen by enable");
    host.wr(CFG_OPT_OFFSET, 8'h41);
    hrst = 1'b1;
    repeat (4) tick();
    chk1(hif_rst, 1'b1, "host reset held");
    hrst = 1'b0;
    repeat (4) tick();
    chk1(hif_rst, 1'b0, "host reset gone");
    reg_is(CFG_OPT_RESET, "host reset clears");
    host.wr(CFG_OPT_OFFSET, 8'h41);
    rst = 1'b1;
    sense = 1'b0;
    tick();
    rst = 1'b0;
    wait_mode();
    chk1(hmode, MODE_PC_ATA, "second sensed mode");
    reg_is(CFG_OPT_RESET, "second power-on");
    wrap_up();
  end
endmodule
`default_nettype wire
